/* verilog/asxr_pkg.sv */
// Purpose: Shared constants for the async serial transmitter/receiver
// Assumes: Byte-wide register port, 3-bit register index
// Notes:   Offsets and field positions are used by name, except in the CTL1 readback, the baud select slices and the reset status check
package asxr_pkg;
	// ----------------------------------------
	// Register indexes
	// ----------------------------------------
	localparam logic [2:0] A_DATA = 3'h0;
	localparam logic [2:0] A_STAT = 3'h1;
	localparam logic [2:0] A_CTL1 = 3'h2;
	localparam logic [2:0] A_CTL2 = 3'h3;
	localparam logic [2:0] A_BAUD = 3'h4;
	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int C1_RX9  = 7;
	localparam int C1_TX9  = 6;
	localparam int C1_M    = 4;
	localparam int C2_TIE  = 7;
	localparam int C2_TX_COMPLETE_IRQ_ENABLE = 6;
	localparam int C2_RIE  = 5;
	localparam int C2_TE   = 3;
	localparam int C2_RE   = 2;
	localparam int C2_SBK  = 0;
	localparam int S_TX_BUFFER_EMPTY_FLAG  = 7;
	localparam int S_TC    = 6;
	localparam int S_RX_BUFFER_FULL_FLAG  = 5;
	localparam int S_OR    = 3;
	localparam int S_NF    = 2;
	localparam int S_FE    = 1;
	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [7:0] CTL2_RST = 8'h00;
	localparam logic [7:0] BAUD_RST = 8'h00;
	localparam logic       TX_BUFFER_EMPTY_FLAG_RST = 1'b1;
	localparam logic       TC_RST   = 1'b1;
	// ----------------------------------------
	// Timing counts
	// ----------------------------------------
	localparam logic [3:0] OVS_LAST  = 4'hf;
	localparam logic [3:0] SMP_FIRST = 4'h7;
	localparam logic [3:0] SMP_MID   = 4'h8;
	localparam logic [3:0] SMP_LAST  = 4'h9;
	localparam logic [3:0] FRM8      = 4'ha;
	localparam logic [3:0] FRM9      = 4'hb;
	localparam logic [3:0] PR_0      = 4'h1;
	localparam logic [3:0] PR_1      = 4'h3;
	localparam logic [3:0] PR_2      = 4'h4;
	localparam logic [3:0] PR_3      = 4'hd;
	// ----------------------------------------
	// States
	// ----------------------------------------
	typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_RUN = 2'b10} asxr_tx_e;
	typedef enum logic [1:0] {RX_HUNT = 2'b01, RX_BITS = 2'b10} asxr_rx_e;
endpackage

/* verilog/asxr_baud.sv */
// Purpose: One baud generator giving a 16x oversampling tick
// Assumes: Selects are stable while the path is enabled
// Notes:   Tick period is prescaler times power-of-two divider
`timescale 1ns/1ps
`default_nettype none
module asxr_baud #(
	parameter int CW = 11
) (
	input  wire logic       clk,
	input  wire logic       srst,
	input  wire logic [1:0] pr_sel,
	input  wire logic [2:0] div_sel,
	output var  logic       tick
);
	logic [3:0]    pr;
	logic [CW-1:0] lim;
	logic [CW-1:0] cnt_q;

	always_comb begin
		case (pr_sel)
			2'd0: pr = asxr_pkg::PR_0;
			2'd1: pr = asxr_pkg::PR_1;
			2'd2: pr = asxr_pkg::PR_2;
			default: pr = asxr_pkg::PR_3;
		endcase
		lim = CW'((CW'(pr) << div_sel) - CW'(1));
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			cnt_q <= '0;
			tick  <= 1'b0;
		end else if (cnt_q >= lim) begin
			cnt_q <= '0;
			tick  <= 1'b1;
		end else begin
			cnt_q <= cnt_q + CW'(1);
			tick  <= 1'b0;
		end
	end
endmodule
`default_nettype wire

/* verilog/asxr_top.sv */
// Purpose: Full-duplex async serial transmitter and receiver
// Assumes: Inputs synchronous to CLK; register port answers next cycle
// Notes:   Behaviour
// Behaviour
// [R1] Enabled and idle: serial output held high.
// [R2] Both paths off: pin returned to general-purpose port.
// [R3] Frame is low start, 8 or 9 data bits LSB first, high stop.
// [R4] Word length bit picks 9 or 8 bits; ninth sent from tx_ninth_bit.
// [R5] In 9-bit mode received MSB goes to rx_ninth_bit.
// [R6] Idle character is a whole frame of ones.
// [R7] After the last break frame one extra high bit is sent.
// [R8] Transmit and receive each have their own baud generator.
// [R9] Setting transmitter-on claims pin and sends one idle frame first.
// [R10] Empty flag clears only by status read then data write.
// [R11] Empty flag set when holding buffer moves to shifter; raises interrupt.
// [R12] Write during a frame waits in buffer until frame ends.
// [R13] Write while idle starts at once and sets empty flag.
// [R14] Complete flag set after stop bit with nothing pending; interrupt.
// [R15] Complete flag cleared by the same status-then-write sequence.
// [R16] Send-break bit set: break frames sent back to back.
// [R17] Transmitter-on toggle inserts idle frame and drops buffered byte.
// [R18] Receiver-on enables continuous start bit search.
// [R19] Completed character moves to buffer and sets full flag.
// [R20] Full flag raises receive interrupt; error flags ride along.
// [R21] Full flag clears only by status read then data read.
// [R22] Software must empty buffer before next character ends.
// [R23] Overrun: flag set, buffer kept, shifter overwritten, interrupt.
// [R24] Bits judged by 8th, 9th, 10th samples; disagreement sets noise.
// [R25] Missing stop bit or break sets framing error, data still moved.
// [R26] Baud is clock over 16 times prescaler times divider.
// [R27] Status read arms; next data access consumes the arm.
//
// The address map and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module asxr_top (
	input  wire logic       CLK,
	input  wire logic       SRST,
	input  wire logic [2:0] ADDR,
	input  wire logic [7:0] WDATA,
	input  wire logic       WR,
	input  wire logic       RD,
	output var  logic [7:0] RDATA,
	input  wire logic       SERIAL_IN_PIN,
	output var  logic       SERIAL_OUT,
	output var  logic       SERIAL_OUT_OE,
	input  wire logic       CPU_IRQ_MASK,
	output var  logic       IRQ
);
	// ----------------------------------------
	// Registers and decode
	// ----------------------------------------
	logic       t8_q, m_q, rx9_q, armed_q;
	logic [7:0] ctl2_q, baud_q, tdr_q, rdr_q, stat;
	logic       tx_buffer_empty_flag_q, tc_q, rx_buffer_full_flag_q, ovr_q, nf_q, fe_q;
	logic       wr_data, rd_data, rd_stat, arm_wr, arm_rd;
	logic       te, re, send_break_bit;

	assign wr_data = WR && (ADDR == asxr_pkg::A_DATA);
	assign rd_data = RD && (ADDR == asxr_pkg::A_DATA);
	assign rd_stat = RD && (ADDR == asxr_pkg::A_STAT);
	assign arm_wr  = wr_data && armed_q; // R10 R15
	assign arm_rd  = rd_data && armed_q; // R21
	assign te      = ctl2_q[asxr_pkg::C2_TE];
	assign re      = ctl2_q[asxr_pkg::C2_RE];
	assign send_break_bit     = ctl2_q[asxr_pkg::C2_SBK];

	always_ff @(posedge CLK) begin
		if (SRST) begin
			t8_q   <= 1'b0;
			m_q    <= 1'b0;
			ctl2_q <= asxr_pkg::CTL2_RST;
			baud_q <= asxr_pkg::BAUD_RST;
		end else if (WR && ADDR == asxr_pkg::A_CTL1) begin
			t8_q <= WDATA[asxr_pkg::C1_TX9];
			m_q  <= WDATA[asxr_pkg::C1_M];
		end else if (WR && ADDR == asxr_pkg::A_CTL2) begin
			ctl2_q <= WDATA;
		end else if (WR && ADDR == asxr_pkg::A_BAUD) begin
			baud_q <= WDATA;
		end
	end

	// Arm survives other register traffic, only data access consumes it
	always_ff @(posedge CLK) begin
		if (SRST) begin
			armed_q <= 1'b0;
		end else if (rd_stat) begin
			armed_q <= 1'b1; // R27
		end else if (wr_data || rd_data) begin
			armed_q <= 1'b0; // R27
		end
	end

	always_comb begin
		stat = 8'h00;
		stat[asxr_pkg::S_TX_BUFFER_EMPTY_FLAG] = tx_buffer_empty_flag_q;
		stat[asxr_pkg::S_TC]   = tc_q;
		stat[asxr_pkg::S_RX_BUFFER_FULL_FLAG] = rx_buffer_full_flag_q;
		stat[asxr_pkg::S_OR]   = ovr_q;
		stat[asxr_pkg::S_NF]   = nf_q;
		stat[asxr_pkg::S_FE]   = fe_q;
	end

	always_ff @(posedge CLK) begin
		if (SRST) begin
			RDATA <= 8'h00;
		end else if (rd_data) begin
			RDATA <= rdr_q;
		end else if (rd_stat) begin
			RDATA <= stat;
		end else if (RD && ADDR == asxr_pkg::A_CTL1) begin
			RDATA <= {rx9_q, t8_q, 1'b0, m_q, 4'h0};
		end else if (RD && ADDR == asxr_pkg::A_CTL2) begin
			RDATA <= ctl2_q;
		end else if (RD && ADDR == asxr_pkg::A_BAUD) begin
			RDATA <= baud_q;
		end else begin
			RDATA <= 8'h00;
		end
	end

	// ----------------------------------------
	// Baud generators
	// ----------------------------------------
	logic tx_tick, rx_tick;

	asxr_baud u_txb ( // R8 R26
		.clk     (CLK),
		.srst    (SRST),
		.pr_sel  (baud_q[7:6]),
		.div_sel (baud_q[5:3]),
		.tick    (tx_tick)
	);

	asxr_baud u_rxb ( // R8 R26
		.clk     (CLK),
		.srst    (SRST),
		.pr_sel  (baud_q[7:6]),
		.div_sel (baud_q[2:0]),
		.tick    (rx_tick)
	);

	// ----------------------------------------
	// Transmitter
	// ----------------------------------------
	asxr_pkg::asxr_tx_e tx_st_q;
	logic [10:0] tx_sr_q;
	logic [3:0]  tx_cnt_q, tx_sub_q, flen;
	logic        te_prev_q, te_rise, te_fall, tdr_full_q, idle_req_q, brk_sent_q;
	logic        bit_end, frame_end, can_load, ld_idle, ld_brk, ld_tail, ld_data, ld_any;

	assign flen      = m_q ? asxr_pkg::FRM9 : asxr_pkg::FRM8;
	assign te_rise   = te && !te_prev_q;
	assign te_fall   = !te && te_prev_q;
	assign bit_end   = (tx_st_q == asxr_pkg::TX_RUN) && tx_tick && (tx_sub_q == asxr_pkg::OVS_LAST);
	assign frame_end = bit_end && (tx_cnt_q == 4'h1);
	assign can_load  = te && ((tx_st_q == asxr_pkg::TX_IDLE) || frame_end);
	assign ld_any    = ld_idle || ld_brk || ld_tail || ld_data;

	// Idle first, then break, then break tail, then data
	always_comb begin
		ld_idle = 1'b0;
		ld_brk  = 1'b0;
		ld_tail = 1'b0;
		ld_data = 1'b0;
		if (can_load) begin
			if (idle_req_q) begin
				ld_idle = 1'b1; // R9 R17
			end else if (send_break_bit) begin
				ld_brk = 1'b1; // R16
			end else if (brk_sent_q) begin
				ld_tail = 1'b1; // R7
			end else if (tdr_full_q) begin
				ld_data = 1'b1; // R12 R13
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (SRST) begin
			tx_st_q  <= asxr_pkg::TX_IDLE;
			tx_sr_q  <= '1;
			tx_cnt_q <= 4'h0;
			tx_sub_q <= 4'h0;
		end else begin
			case (tx_st_q)
				asxr_pkg::TX_IDLE: begin
					if (ld_any) begin
						tx_st_q <= asxr_pkg::TX_RUN;
					end
				end
				default: begin
					if (frame_end && !ld_any) begin
						tx_st_q <= asxr_pkg::TX_IDLE;
					end
				end
			endcase
			if (ld_any) begin
				tx_sub_q <= 4'h0;
				tx_cnt_q <= ld_tail ? 4'h1 : flen; // R7
				if (ld_data && m_q) begin
					tx_sr_q <= {1'b1, t8_q, tdr_q, 1'b0}; // R3 R4
				end else if (ld_data) begin
					tx_sr_q <= {2'b11, tdr_q, 1'b0}; // R3
				end else if (ld_brk) begin
					tx_sr_q <= '0; // R16
				end else begin
					tx_sr_q <= '1; // R6
				end
			end else if (tx_st_q == asxr_pkg::TX_RUN && tx_tick) begin
				tx_sub_q <= tx_sub_q + 4'h1;
				if (bit_end) begin
					tx_sr_q  <= {1'b1, tx_sr_q[10:1]};
					tx_cnt_q <= tx_cnt_q - 4'h1;
				end
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (SRST) begin
			te_prev_q  <= 1'b0;
			idle_req_q <= 1'b0;
			brk_sent_q <= 1'b0;
		end else begin
			te_prev_q <= te;
			if (te_rise) begin
				idle_req_q <= 1'b1; // R9 R17
			end else if (ld_idle) begin
				idle_req_q <= 1'b0;
			end
			if (ld_brk) begin
				brk_sent_q <= 1'b1;
			end else if (ld_tail) begin
				brk_sent_q <= 1'b0; // R7
			end
		end
	end

	// Toggling transmitter-on loses a buffered byte; a new write still wins
	always_ff @(posedge CLK) begin
		if (SRST) begin
			tdr_q      <= 8'h00;
			tdr_full_q <= 1'b0;
		end else if (wr_data) begin
			tdr_q      <= WDATA; // R12
			tdr_full_q <= 1'b1;
		end else if (ld_data || te_fall) begin
			tdr_full_q <= 1'b0; // R17
		end
	end

	always_ff @(posedge CLK) begin
		if (SRST) begin
			tx_buffer_empty_flag_q <= asxr_pkg::TX_BUFFER_EMPTY_FLAG_RST;
			tc_q   <= asxr_pkg::TC_RST;
		end else begin
			if (ld_data) begin
				tx_buffer_empty_flag_q <= 1'b1; // R11 R13
			end else if (arm_wr) begin
				tx_buffer_empty_flag_q <= 1'b0; // R10
			end
			if (frame_end && !ld_any) begin
				tc_q <= 1'b1; // R14
			end else if (arm_wr) begin
				tc_q <= 1'b0; // R15
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (SRST) begin
			SERIAL_OUT    <= 1'b1;
			SERIAL_OUT_OE <= 1'b0;
		end else begin
			SERIAL_OUT    <= (tx_st_q == asxr_pkg::TX_RUN) ? tx_sr_q[0] : 1'b1; // R1
			SERIAL_OUT_OE <= te || re; // R2 R9
		end
	end

	// ----------------------------------------
	// Receiver
	// ----------------------------------------
	asxr_pkg::asxr_rx_e rx_st_q;
	logic [3:0] rx_sub_q, rx_idx_q, rx_last;
	logic [1:0] smp_q;
	logic [8:0] rsr_q;
	logic       rx_prev_q, nf_acc_q, vote, noisy, at_vote, rx_done;

	assign rx_last = flen - 4'h1;
	assign vote    = (smp_q[1] & smp_q[0]) | (smp_q[1] & SERIAL_IN_PIN) | (smp_q[0] & SERIAL_IN_PIN); // R24
	assign noisy   = (smp_q[1] != smp_q[0]) || (smp_q[0] != SERIAL_IN_PIN); // R24
	assign at_vote = (rx_st_q == asxr_pkg::RX_BITS) && rx_tick && (rx_sub_q == asxr_pkg::SMP_LAST);
	assign rx_done = at_vote && (rx_idx_q == rx_last);

	always_ff @(posedge CLK) begin
		if (SRST) begin
			rx_st_q   <= asxr_pkg::RX_HUNT;
			rx_sub_q  <= 4'h0;
			rx_idx_q  <= 4'h0;
			smp_q     <= 2'b11;
			rsr_q     <= 9'h000;
			rx_prev_q <= 1'b1;
		end else if (!re) begin
			rx_st_q   <= asxr_pkg::RX_HUNT;
			rx_prev_q <= 1'b1;
		end else if (rx_tick) begin
			rx_prev_q <= SERIAL_IN_PIN;
			case (rx_st_q)
				asxr_pkg::RX_HUNT: begin
					if (rx_prev_q && !SERIAL_IN_PIN) begin
						rx_st_q  <= asxr_pkg::RX_BITS; // R18
						rx_sub_q <= 4'h1;
						rx_idx_q <= 4'h0;
					end
				end
				default: begin
					rx_sub_q <= rx_sub_q + 4'h1;
					if (rx_sub_q == asxr_pkg::SMP_FIRST) begin
						smp_q[1] <= SERIAL_IN_PIN;
					end
					if (rx_sub_q == asxr_pkg::SMP_MID) begin
						smp_q[0] <= SERIAL_IN_PIN;
					end
					if (at_vote) begin
						rx_idx_q <= rx_idx_q + 4'h1;
						if ((rx_idx_q == 4'h0 && vote) || rx_done) begin
							rx_st_q <= asxr_pkg::RX_HUNT; // R24
						end else if (rx_idx_q != 4'h0) begin
							rsr_q <= {vote, rsr_q[8:1]}; // R3 R23
						end
					end
				end
			endcase
		end
	end

	// False starts leave noise pending for the next good frame
	always_ff @(posedge CLK) begin
		if (SRST) begin
			nf_acc_q <= 1'b0;
		end else if (rx_done) begin
			nf_acc_q <= 1'b0;
		end else if (at_vote && noisy) begin
			nf_acc_q <= 1'b1; // R24
		end
	end

	always_ff @(posedge CLK) begin
		if (SRST) begin
			rdr_q  <= 8'h00;
			rx9_q  <= 1'b0;
			rx_buffer_full_flag_q <= 1'b0;
			ovr_q  <= 1'b0;
			nf_q   <= 1'b0;
			fe_q   <= 1'b0;
		end else if (rx_done && rx_buffer_full_flag_q) begin
			ovr_q <= 1'b1; // R23
		end else if (rx_done) begin
			rdr_q  <= m_q ? rsr_q[7:0] : rsr_q[8:1]; // R19 R25
			rx9_q  <= m_q ? rsr_q[8] : rx9_q; // R5
			rx_buffer_full_flag_q <= 1'b1; // R19
			nf_q   <= nf_acc_q || noisy; // R24
			fe_q   <= !vote; // R25
		end else if (arm_rd) begin
			rx_buffer_full_flag_q <= 1'b0; // R21
			ovr_q  <= 1'b0;
			nf_q   <= 1'b0;
			fe_q   <= 1'b0;
		end
	end

	always_ff @(posedge CLK) begin
		if (SRST) begin
			IRQ <= 1'b0;
		end else begin
			IRQ <= !CPU_IRQ_MASK && ((ctl2_q[asxr_pkg::C2_TIE] && tx_buffer_empty_flag_q) // R11
				|| (ctl2_q[asxr_pkg::C2_TX_COMPLETE_IRQ_ENABLE] && tc_q) // R14
				|| (ctl2_q[asxr_pkg::C2_RIE] && (rx_buffer_full_flag_q || ovr_q))); // R20 R23
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge CLK); endclocking
	default disable iff (SRST);

	AST_IDLE_HIGH: assert property (tx_st_q == asxr_pkg::TX_IDLE |=> SERIAL_OUT) // R1
		else $error("serial out not high while idle");
	AST_PIN_FREE: assert property (!te && !re |=> !SERIAL_OUT_OE) // R2
		else $error("pin kept while both paths off");
	AST_START_LOW: assert property (ld_data |-> ##2 !SERIAL_OUT) // R3
		else $error("start bit not low");
	AST_NINTH_TX: assert property (ld_data && m_q |=> tx_sr_q[9] == $past(t8_q)) // R4
		else $error("ninth bit not from control");
	AST_NINTH_RX: assert property (rx_done && !rx_buffer_full_flag_q && m_q |=> rx9_q == $past(rsr_q[8])) // R5
		else $error("received ninth bit lost");
	AST_TX_BUFFER_EMPTY_FLAG_SET: assert property (ld_data |=> tx_buffer_empty_flag_q && !tdr_full_q || $past(wr_data)) // R11
		else $error("empty flag not set on transfer");
	AST_TX_BUFFER_EMPTY_FLAG_HOLD: assert property (tx_buffer_empty_flag_q && !arm_wr |=> tx_buffer_empty_flag_q) // R10
		else $error("empty flag cleared without sequence");
	AST_TC_SET: assert property (frame_end && !ld_any |=> tc_q ##1 tx_st_q == asxr_pkg::TX_IDLE) // R14
		else $error("complete flag not set");
	AST_RX_BUFFER_FULL_FLAG: assert property (rx_done && !rx_buffer_full_flag_q |=> rx_buffer_full_flag_q && rdr_q == (m_q ? $past(rsr_q[7:0]) : $past(rsr_q[8:1]))) // R19
		else $error("character not moved to buffer");
	AST_OVR: assert property (rx_done && rx_buffer_full_flag_q |=> ovr_q && $stable(rdr_q)) // R23
		else $error("overrun mishandled");
	AST_RX_BUFFER_FULL_FLAG_HOLD: assert property (rx_buffer_full_flag_q && !arm_rd |=> rx_buffer_full_flag_q) // R21
		else $error("full flag cleared without sequence");

	COV_DATA: cover property (ld_data ##[1:300] frame_end);
	COV_BREAK: cover property (ld_brk ##[1:1000] ld_tail);
	COV_OVR: cover property (rx_done && rx_buffer_full_flag_q);
	COV_IDLE: cover property (ld_idle);
endmodule
`default_nettype wire

/* bench/asxr_far.sv */
// Purpose: Far-end serial equipment for the async serial block
// Assumes: Bit lengths are counted in CLK cycles
// Notes:   Line is driven high between frames, as a mark-idle link
`timescale 1ns/1ps
`default_nettype none
module asxr_far #(
	parameter int TXB = 16,
	parameter int RXB = 32
) (
	input  wire logic clk,
	input  wire logic line_in,
	input  wire logic oe,
	input  wire logic nine,
	output var  logic line_out
);
	// ----------------------------------------
	// Receive side
	// ----------------------------------------
	logic [9:0] got [$];
	logic [9:0] w;
	int         i;
	initial line_out = 1'b1;
	// Centre sampling; stop level kept in bit 9 so a break shows as all zero
	always begin
		@(posedge clk);
		if (oe && line_in === 1'b0) begin
			w = '0;
			repeat (RXB / 2) @(posedge clk);
			for (i = 0; i < (nine ? 9 : 8); i++) begin
				repeat (RXB) @(posedge clk);
				w[i] = line_in;
			end
			repeat (RXB) @(posedge clk);
			w[9] = line_in;
			got.push_back(w);
			wait (line_in === 1'b1);
		end
	end
	// ----------------------------------------
	// Send side
	// ----------------------------------------
	task automatic send(input logic [8:0] d, input int nb, input logic stp);
		int k;
		@(posedge clk);
		line_out <= 1'b0;
		repeat (TXB) @(posedge clk);
		for (k = 0; k < nb; k++) begin
			line_out <= d[k];
			repeat (TXB) @(posedge clk);
		end
		line_out <= stp;
		repeat (TXB) @(posedge clk);
		line_out <= 1'b1;
	endtask
endmodule
`default_nettype wire

/* bench/testbench.sv */
// Purpose: Self-checking bench for the async serial block
// Assumes: Transmit bit is 32 clocks, receive bit 16 clocks
// Notes:   Rates differ on purpose so a shared generator would show up
`timescale 1ns/1ps
`default_nettype none
module testbench;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic       clk = 1'b0;
	logic       srst = 1'b1;
	logic       wr = 1'b0;
	logic       rd = 1'b0;
	logic       mask = 1'b0;
	logic       nine = 1'b0;
	logic [2:0] addr = 3'h0;
	logic [7:0] wdata = 8'h00;
	logic [7:0] rdata;
	logic [7:0] rv;
	logic       sin;
	logic       sout;
	logic       soe;
	logic       irq;
	int         miscompares = 0;
	int         n_checks = 0;
	int         cyc = 0;
	localparam logic [7:0] TE   = 8'h01 << asxr_pkg::C2_TE;
	localparam logic [7:0] RE   = 8'h01 << asxr_pkg::C2_RE;
	localparam logic [7:0] SEND_BREAK_BIT  = 8'h01 << asxr_pkg::C2_SBK;
	localparam logic [7:0] TX_COMPLETE_IRQ_ENABLE = 8'h01 << asxr_pkg::C2_TX_COMPLETE_IRQ_ENABLE;
	localparam logic [7:0] RX_IRQ_ENABLE  = 8'h01 << asxr_pkg::C2_RIE;
	localparam logic [7:0] M9   = (8'h01 << asxr_pkg::C1_M) | (8'h01 << asxr_pkg::C1_TX9);

	asxr_top dut (.CLK(clk), .SRST(srst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
		.SERIAL_IN_PIN(sin), .SERIAL_OUT(sout), .SERIAL_OUT_OE(soe), .CPU_IRQ_MASK(mask), .IRQ(irq));
	asxr_far #(.TXB(16), .RXB(32)) far (.clk(clk), .line_in(sout), .oe(soe), .nine(nine), .line_out(sin));

	always #12.5 clk = ~clk;
	// Hang guard: the whole run needs well under 10000 cycles
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			miscompares++;
			results();
		end
	end
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic results;
		if (miscompares == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
		n_checks++;
		if (g !== e) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic bw(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// Read data stands only in the cycle after the strobe
	task automatic br(input logic [2:0] a);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 rv = rdata;
	endtask
	task automatic wait_got(input int n);
		int k;
		for (k = 0; k < 3000 && far.got.size() < n; k++)
			@(posedge clk);
		chk("frame count", 10'(n), 10'(far.got.size()));
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset;
		br(asxr_pkg::A_STAT);
		chk("reset status", 10'h0c0, 10'(rv));
		br(3'h7);
		chk("unmapped read", 10'h000, 10'(rv));
		chk("pin released", 10'h0, 10'(soe));
		chk("line level", 10'h1, 10'(sout));
	endtask
	task automatic t_tx;
		int k;
		int bad;
		bad = 0;
		bw(asxr_pkg::A_BAUD, 8'h08);
		bw(asxr_pkg::A_CTL2, TE);
		repeat (3) @(posedge clk);
		chk("pin claimed", 10'h1, 10'(soe));
		for (k = 0; k < 300; k++) begin
			@(posedge clk);
			if (sout !== 1'b1)
				bad++;
		end
		chk("idle frame", 10'h0, 10'(bad));
		repeat (60) @(posedge clk);
		br(asxr_pkg::A_STAT);
		bw(asxr_pkg::A_DATA, 8'ha5);
		repeat (2) @(posedge clk);
		br(asxr_pkg::A_STAT);
		chk("empty at once", 10'h1, 10'(rv[asxr_pkg::S_TX_BUFFER_EMPTY_FLAG]));
		chk("complete cleared", 10'h0, 10'(rv[asxr_pkg::S_TC]));
		br(asxr_pkg::A_STAT);
		bw(asxr_pkg::A_DATA, 8'h3c);
		repeat (2) @(posedge clk);
		br(asxr_pkg::A_STAT);
		chk("empty cleared", 10'h0, 10'(rv[asxr_pkg::S_TX_BUFFER_EMPTY_FLAG]));
		wait_got(2);
		chk("first frame", 10'h2a5, far.got[0]);
		chk("second frame", 10'h23c, far.got[1]);
		repeat (40) @(posedge clk);
		br(asxr_pkg::A_STAT);
		chk("empty set", 10'h1, 10'(rv[asxr_pkg::S_TX_BUFFER_EMPTY_FLAG]));
		chk("complete set", 10'h1, 10'(rv[asxr_pkg::S_TC]));
		bw(asxr_pkg::A_CTL2, TE | TX_COMPLETE_IRQ_ENABLE);
		repeat (3) @(posedge clk);
		chk("complete irq", 10'h1, 10'(irq));
		mask <= 1'b1;
		repeat (3) @(posedge clk);
		chk("masked irq", 10'h0, 10'(irq));
		mask <= 1'b0;
	endtask
	task automatic t_break;
		bw(asxr_pkg::A_CTL2, TE | SEND_BREAK_BIT);
		wait_got(3);
		chk("break frame", 10'h000, far.got[2]);
		bw(asxr_pkg::A_CTL2, TE);
		br(asxr_pkg::A_STAT);
		bw(asxr_pkg::A_DATA, 8'h11);
		wait_got(4);
		chk("frame after break", 10'h211, far.got[3]);
	endtask
	task automatic t_rx;
		bw(asxr_pkg::A_CTL2, TE | RE);
		br(asxr_pkg::A_DATA);
		far.send(9'h096, 8, 1'b1);
		repeat (4) @(posedge clk);
		br(asxr_pkg::A_DATA);
		chk("rx data", 10'h096, 10'(rv));
		br(asxr_pkg::A_STAT);
		chk("full kept", 10'h1, 10'(rv[asxr_pkg::S_RX_BUFFER_FULL_FLAG]));
		chk("clean noise", 10'h0, 10'(rv[asxr_pkg::S_NF]));
		chk("clean framing", 10'h0, 10'(rv[asxr_pkg::S_FE]));
		far.send(9'h03c, 8, 1'b1);
		repeat (4) @(posedge clk);
		br(asxr_pkg::A_STAT);
		chk("overrun", 10'h1, 10'(rv[asxr_pkg::S_OR]));
		br(asxr_pkg::A_DATA);
		chk("buffer kept", 10'h096, 10'(rv));
		br(asxr_pkg::A_STAT);
		chk("full cleared", 10'h0, 10'(rv[asxr_pkg::S_RX_BUFFER_FULL_FLAG]));
		chk("overrun cleared", 10'h0, 10'(rv[asxr_pkg::S_OR]));
		far.send(9'h055, 8, 1'b0);
		repeat (4) @(posedge clk);
		br(asxr_pkg::A_STAT);
		chk("framing", 10'h1, 10'(rv[asxr_pkg::S_FE]));
		bw(asxr_pkg::A_CTL2, TE | RE | RX_IRQ_ENABLE);
		repeat (3) @(posedge clk);
		chk("rx irq", 10'h1, 10'(irq));
		br(asxr_pkg::A_DATA);
		chk("framed data", 10'h055, 10'(rv));
		repeat (3) @(posedge clk);
		chk("rx irq gone", 10'h0, 10'(irq));
	endtask
	task automatic t_nine;
		nine <= 1'b1;
		bw(asxr_pkg::A_CTL1, M9);
		br(asxr_pkg::A_STAT);
		bw(asxr_pkg::A_DATA, 8'h5a);
		wait_got(5);
		chk("nine tx", 10'h35a, far.got[4]);
		far.send(9'h181, 9, 1'b1);
		repeat (4) @(posedge clk);
		br(asxr_pkg::A_CTL1);
		chk("rx ninth", 10'h1, 10'(rv[asxr_pkg::C1_RX9]));
		br(asxr_pkg::A_DATA);
		chk("nine rx low", 10'h081, 10'(rv));
	endtask
	task automatic t_off;
		bw(asxr_pkg::A_CTL2, 8'h00);
		repeat (3) @(posedge clk);
		chk("pin returned", 10'h0, 10'(soe));
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (12) @(posedge clk);
		srst <= 1'b0;
		t_reset();
		t_tx();
		t_break();
		t_rx();
		t_nine();
		t_off();
		results();
	end
endmodule
`default_nettype wire
